//--- common/pm_cfg_pkg.sv
// Types and constants of the configuration bank.
// Assumes a single 125 MHz clock and a plain strobe register port.
package pm_cfg_pkg;

  // ==========================================================
  // Register indices
  localparam logic [7:0] IDX_CACHE_TIMING = 8'h5A;
  localparam logic [7:0] IDX_MGMT_MODE    = 8'h5B;
  localparam logic [7:0] IDX_TRAP_ONE     = 8'h5C;
  localparam logic [7:0] IDX_TRAP_TWO     = 8'h5D;
  localparam logic [7:0] IDX_TRAP_THREE   = 8'h5E;
  localparam logic [7:0] IDX_FLASH_TB     = 8'h5F;
  localparam logic [7:0] IDX_BUS_CLOCK    = 8'h60;
  localparam logic [7:0] IDX_BUS_RECOVERY = 8'h61;
  localparam logic [7:0] IDX_RSVD_62      = 8'h62;
  localparam logic [7:0] IDX_RAM_BREAK    = 8'h63;
  // Request status, offset chosen for this block
  localparam logic [7:0] IDX_REQ_STATUS   = 8'h69;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CACHE_TIMING = 8'h00;
  localparam logic [7:0] RST_MGMT_MODE    = 8'h00;
  localparam logic [7:0] RST_TRAP         = 8'h00;
  localparam logic [7:0] RST_FLASH_TB     = 8'h00;
  localparam logic [7:0] RST_BUS_CLOCK    = 8'h00;
  localparam logic [7:0] RST_BUS_RECOVERY = 8'h09;
  localparam logic [7:0] RST_RSVD_62      = 8'h40;
  localparam logic [7:0] RST_RAM_BREAK    = 8'h00;

  // ==========================================================
  // Field positions
  localparam int B_CACHE_2T      = 6;
  localparam int B_SLOW_SPEED    = 4;
  localparam int B_BURST_FAST    = 1;
  localparam int B_CAS_DELAY     = 0;
  localparam int B_MGMT_EN       = 7;
  localparam int B_STOP_EN       = 6;
  localparam int B_STOP_AUTO     = 5;
  localparam int B_REQ_BY_PIN    = 4;
  localparam int B_IRQ_SEL       = 3;
  localparam int B_CLK_AUTO      = 2;
  localparam int B_RELOC_N       = 1;
  localparam int B_PIN_MUX       = 7;
  localparam int B_STROBE_LVL    = 6;
  localparam int B_STROBE_PROG   = 5;
  localparam int B_RELOAD_ALL    = 4;
  localparam int B_TB_LO         = 2;
  localparam int B_BREAK_INT     = 0;
  localparam int B_BCLK_LO       = 5;
  localparam int B_ZERO_WAIT     = 4;
  localparam int B_NO_CMD_DELAY  = 3;
  localparam int B_SHORT_READ    = 2;
  localparam int B_REC16_LO      = 6;
  localparam int B_REC8_LO       = 4;
  localparam int B_WAIT16        = 2;
  localparam int B_WAIT8         = 1;
  localparam int B_RAM_AREA_LO   = 5;
  localparam int B_RAM_OPEN      = 4;
  localparam int B_STAT_BREAK    = 3;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ         = 125;
  localparam int RESTORE_MS      = 30;
  localparam int RESTORE_CYCLES  = RESTORE_MS * 1000 * CLK_MHZ;
  localparam int IO_PORT_ARM     = 16'h0043;
  localparam int IO_PORT_FIRE    = 16'h0070;

  // ==========================================================
  // Grouped types
  typedef struct packed {
    logic [2:0] clk_sel;
    logic       zero_wait16;
    logic       read_no_delay;
    logic       read_short;
    logic [4:0] rec16_clks;
    logic [4:0] rec8_clks;
    logic [2:0] wait16;
    logic [2:0] wait8;
  } bus_timing_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [15:0] addr;
  } io_cycle_t;

  typedef enum logic [1:0] {ARM_IDLE, ARM_SEEN} arm_state_t;

endpackage

//--- tb/host_io_model.sv
// Host side model: issues one-cycle I/O read or write pulses.
// Assumes one bench process calls cycle() at a time.
`timescale 1ns/1ns
`default_nettype none
module host_io_model (
  input  wire logic                  clk,
  output var  pm_cfg_pkg::io_cycle_t io
);
  import pm_cfg_pkg::*;

  initial io = '{rd: 1'b0, wr: 1'b0, addr: 16'hFFFF};

  // ==========
  // One host I/O cycle, address inverted after
  task automatic cycle(input logic rd, input logic [15:0] a);
    @(posedge clk);
    io <= '{rd: rd, wr: !rd, addr: a};
    @(posedge clk);
    io <= '{rd: 1'b0, wr: 1'b0, addr: ~a};
  endtask
endmodule
`default_nettype wire

//--- tb/pm_cfg_regs_monitor.sv
// Checker bound to the configuration bank.
// Assumes one-cycle register strobes and read data one cycle on.
`timescale 1ns/1ns
`default_nettype none
module pm_cfg_regs_monitor (
  input wire logic                    CLK,
  input wire logic                    ARST_N,
  input wire logic [7:0]              REG_ADDR,
  input wire logic [7:0]              REG_WDATA,
  input wire logic                    REG_WR,
  input wire logic                    REG_RD,
  input wire logic [7:0]              REG_RDATA,
  input wire pm_cfg_pkg::io_cycle_t   IO_CYCLE,
  input wire logic                    SLOW_SPEED_SWITCH,
  input wire logic                    MGMT_OUTPUT_ZERO,
  input wire logic                    MGMT_ACTIVE_INPUT_N,
  input wire logic                    STOP_CLOCK_REQUEST_N,
  input wire logic                    MGMT_INTERRUPT_PIN_N,
  input wire logic                    IRQ12_REQ,
  input wire logic                    IRQ15_REQ,
  input wire logic                    BUS_CLOCK_SLOW,
  input wire logic                    SHARED_PIN,
  input wire logic [1:0]              TIME_BASE,
  input wire pm_cfg_pkg::bus_timing_t BUS_TIMING,
  input wire logic                    MGMT_MEMORY_ALLOW
);
  import pm_cfg_pkg::*;

  localparam logic [4:0] REC16 [4] = '{5'h08, 5'h05, 5'h03, 5'h02};
  localparam logic [4:0] REC8 [4] = '{5'h10, 5'h0B, 5'h07, 5'h04};
  logic [7:0] r5b_q, r5f_q, r60_q, r61_q, r63_q;
  logic       arm_q;

  // ==========
  // Shadows of written registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {r5b_q, r5f_q, r60_q, r63_q} <= '0;
      r61_q <= RST_BUS_RECOVERY;
    end else if (REG_WR) begin
      if (REG_ADDR == IDX_MGMT_MODE) r5b_q <= REG_WDATA;
      if (REG_ADDR == IDX_FLASH_TB) r5f_q <= REG_WDATA;
      if (REG_ADDR == IDX_BUS_CLOCK) r60_q <= REG_WDATA;
      if (REG_ADDR == IDX_BUS_RECOVERY) r61_q <= REG_WDATA;
      if (REG_ADDR == IDX_RAM_BREAK) r63_q <= REG_WDATA;
    end
  end

  // Any other I/O cycle breaks the port pair
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      arm_q <= 1'b0;
    end else if (IO_CYCLE.rd || IO_CYCLE.wr) begin
      arm_q <= IO_CYCLE.rd && IO_CYCLE.addr == 16'h0043;
    end
  end

  // ==========
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  chk_idle_read_zero:
    assert property (!REG_RD |=> REG_RDATA == 8'h00)
    else $error("idle read data");
  chk_unmapped_zero:
    assert property (REG_RD && !(REG_ADDR inside {[8'h5A:8'h63], 8'h69})
      |=> REG_RDATA == 8'h00)
    else $error("unmapped data");
  chk_slow_bit_live:
    assert property (REG_RD && REG_ADDR == 8'h5A && $stable(SLOW_SPEED_SWITCH)
      |=> REG_RDATA[4] == $past(SLOW_SPEED_SWITCH))
    else $error("speed bit");
  chk_mode_gate:
    assert property (!r5b_q[7] && !$past(r5b_q[7])
      |-> MGMT_INTERRUPT_PIN_N && !IRQ12_REQ && !IRQ15_REQ)
    else $error("mode gate");
  chk_stop_seq_fire:
    assert property (IO_CYCLE.rd && IO_CYCLE.addr == 16'h0070 && arm_q
      && r5b_q[6] && r63_q[3:0] == 4'h0 |-> ##2 !STOP_CLOCK_REQUEST_N)
    else $error("no stop request");
  chk_shared_pin_route:
    assert property ($past(ARST_N) && $stable(r5f_q)
      && $stable(MGMT_OUTPUT_ZERO) |-> SHARED_PIN
      == (r5f_q[7] ? (!r5f_q[5] || r5f_q[6]) : MGMT_OUTPUT_ZERO))
    else $error("shared pin");
  chk_time_base_sel:
    assert property ($past(ARST_N) && $stable(r5f_q)
      |-> TIME_BASE == r5f_q[3:2])
    else $error("time base");
  chk_recovery_decode:
    assert property ($past(ARST_N) && $stable(r61_q) |->
      BUS_TIMING.rec16_clks == REC16[r61_q[7:6]]
      && BUS_TIMING.rec8_clks == REC8[r61_q[5:4]]
      && BUS_TIMING.wait16 == (r61_q[2] ? 3'h1 : 3'h2)
      && BUS_TIMING.wait8 == (r61_q[1] ? 3'h4 : 3'h5))
    else $error("recovery decode");
  chk_bus_clock_fields:
    assert property ($past(ARST_N) && $stable(r60_q) && !r5b_q[2]
      && !$past(r5b_q[2]) && !BUS_CLOCK_SLOW |->
      {BUS_TIMING.clk_sel, BUS_TIMING.zero_wait16, BUS_TIMING.read_no_delay,
       BUS_TIMING.read_short} == r60_q[7:2])
    else $error("bus clock fields");
  chk_ram_gate_closed:
    assert property ($stable(r63_q) && !r63_q[4] && MGMT_ACTIVE_INPUT_N
      && $past(MGMT_ACTIVE_INPUT_N) |-> !MGMT_MEMORY_ALLOW)
    else $error("memory gate");
endmodule

bind pm_cfg_regs pm_cfg_regs_monitor i_mon (.*);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the configuration bank.
// Assumes the default restore count, never waited out.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pm_cfg_pkg::*;

  logic        CLK, ARST_N, REG_WR, REG_RD;
  logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, d;
  io_cycle_t   IO_CYCLE;
  logic        SLOW_SPEED_SWITCH, WRITEBACK_CPU, TIMER_EXPIRED, BREAK_SWITCH;
  logic        SW_PORT_HIT, STANDBY_RELOAD_EVENT, MGMT_OUTPUT_N_ACTIVE;
  logic        MGMT_OUTPUT_ZERO, SHADOW_D_E, VECTOR_FETCH, RAM_CYCLE;
  logic        MGMT_ACTIVE_INPUT_N, IRQ_REQ, NMI_REQ, DMA_REQ, MASTER_REQ;
  logic [3:0]  DRAM_SIZE_MB;
  logic [9:0]  FETCH_ADDR;
  logic        CACHE_FIRST_2T, BURST_FAST_OK, CAS_DELAY_1T, IDLE_BREAK;
  logic        STOP_CLOCK_REQUEST_N, MGMT_INTERRUPT_PIN_N, IRQ12_REQ;
  logic        IRQ15_REQ, BUS_CLOCK_SLOW, RELOCATE_256K, VECTOR_EVENT;
  logic        SHARED_PIN, EVENT_TIMER_RELOAD, ALT_PIN_TIMING;
  logic        MGMT_MEMORY_ALLOW;
  logic [1:0]  TIME_BASE;
  logic [2:0]  MGMT_MEMORY_AREA;
  bus_timing_t BUS_TIMING;
  int          errors, checks_done, i, k;
  integer      seed;
  logic [7:0]  msk [10] = '{8'h53, 8'hFA, 8'hFF, 8'hFF, 8'hFF, 8'hFD,
                            8'hFC, 8'hF6, 8'h00, 8'hFF};
  logic [7:0]  mv [5] = '{8'h30, 8'hB0, 8'h80, 8'h88, 8'h98};
  logic [3:0]  ex [5] = '{4'h8, 4'h0, 4'hD, 4'hB, 4'h1};

  host_io_model i_host (.clk(CLK), .io(IO_CYCLE));

  pm_cfg_regs i_dut (.*);

  always #4 CLK = ~CLK;

  // ==========
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK);
    {REG_ADDR, REG_WDATA, REG_WR} <= {a, v, 1'b1};
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    {REG_ADDR, REG_RD} <= {a, 1'b1};
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, exp);
  endtask

  function automatic logic reloc(input logic [3:0] s, input logic sh);
    return !sh && (s inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8});
  endfunction

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Run needs about 430 cycles
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end

  // ==========
  // Main sequence
  initial begin
    seed = 32'h0000_ebd7;
    {CLK, ARST_N, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
    {SLOW_SPEED_SWITCH, WRITEBACK_CPU, TIMER_EXPIRED, BREAK_SWITCH} = '0;
    {SW_PORT_HIT, STANDBY_RELOAD_EVENT, MGMT_OUTPUT_N_ACTIVE} = '0;
    {MGMT_OUTPUT_ZERO, SHADOW_D_E, DRAM_SIZE_MB, VECTOR_FETCH} = '0;
    {FETCH_ADDR, RAM_CYCLE, IRQ_REQ, NMI_REQ, DMA_REQ, MASTER_REQ} = '0;
    {MGMT_ACTIVE_INPUT_N, errors, checks_done} = '0;
    tick(16);
    ARST_N <= 1'b1;
    for (i = 0; i < 10; i++) rchk(8'h5A + 8'(i), i == 7 ? RST_BUS_RECOVERY
                                  : i == 8 ? RST_RSVD_62 : RST_TRAP);
    // Reserved bits as required
    for (i = 0; i < 40; i++) begin
      k = $unsigned($random(seed)) % 10;
      if (k == 8) k = 9;
      d = (8'($random(seed)) & msk[k]) | (k == 7 ? 8'h09 : 8'h00);
      {MGMT_OUTPUT_ZERO, MGMT_ACTIVE_INPUT_N, SLOW_SPEED_SWITCH, RAM_CYCLE,
       STANDBY_RELOAD_EVENT} <= 5'($random(seed));
      wr(8'h5A + 8'(k), d);
      rchk(8'h5A + 8'(k),
           k == 0 ? {d[7:5], SLOW_SPEED_SWITCH, d[3:0]} : d);
    end
    {RAM_CYCLE, STANDBY_RELOAD_EVENT, WRITEBACK_CPU} <= 3'b001;
    wr(8'h64, 8'hFF);
    rchk(8'h64, 8'h00);
    rchk(8'hFF, 8'h00);
    wr(8'h63, 8'h00);
    wr(8'h5D, 8'hFF);
    wr(8'h5E, 8'hFF);
    for (i = 0; i < 2; i++) begin
      wr(8'h5A, i ? 8'h43 : 8'h00);
      tick(1);
      #1 chk({CACHE_FIRST_2T, BURST_FAST_OK}, {i[0], i[0]});
      chk(CAS_DELAY_1T, i[0]);
    end
    for (i = 0; i < 5; i++) begin
      wr(8'h5B, 8'h00);
      wr(8'h5B, mv[i]);
      @(posedge CLK);
      {TIMER_EXPIRED, BREAK_SWITCH, SW_PORT_HIT} <= 3'b100 >> (i % 3);
      @(posedge CLK);
      {TIMER_EXPIRED, BREAK_SWITCH, SW_PORT_HIT} <= 3'b000;
      #1 chk({MGMT_INTERRUPT_PIN_N, IRQ12_REQ, IRQ15_REQ}, ex[i][3:1]);
      tick(2);
      #1 chk(STOP_CLOCK_REQUEST_N, ex[i][0]);
    end
    wr(8'h5B, 8'h50);
    i_host.cycle(1'b1, 16'h0043);
    i_host.cycle(1'b0, 16'h0080);
    i_host.cycle(1'b1, 16'h0070);
    tick(3);
    #1 chk(STOP_CLOCK_REQUEST_N, 1'b1);
    i_host.cycle(1'b1, 16'h0043);
    i_host.cycle(1'b1, 16'h0070);
    tick(2);
    #1 chk(STOP_CLOCK_REQUEST_N, 1'b0);
    wr(8'h63, 8'h08);
    IRQ_REQ <= 1'b1;
    tick(3);
    IRQ_REQ <= 1'b0;
    #1 chk(STOP_CLOCK_REQUEST_N, 1'b1);
    chk(IDLE_BREAK, 1'b1);
    wr(8'h5C, 8'h08);
    for (i = 0; i < 2; i++) begin
      @(posedge CLK);
      {VECTOR_FETCH, FETCH_ADDR} <= {1'b1, i ? 10'h024 : 10'h020};
      @(posedge CLK);
      {VECTOR_FETCH, FETCH_ADDR} <= {1'b0, 10'h3FF};
      #1 chk(VECTOR_EVENT, i[0]);
    end
    wr(8'h5B, 8'h00);
    for (i = 0; i < 32; i++) begin
      @(posedge CLK);
      {SHADOW_D_E, DRAM_SIZE_MB} <= i[4:0];
      tick(2);
      #1 chk(RELOCATE_256K, reloc(i[3:0], i[4]));
    end
    {SHADOW_D_E, DRAM_SIZE_MB} <= 5'h01;
    wr(8'h5B, 8'h02);
    tick(1);
    #1 chk(RELOCATE_256K, 1'b0);
    for (i = 0; i < 8; i++) begin
      wr(8'h60, {i[2:0], 5'h10});
      tick(1);
      #1 chk({BUS_TIMING.clk_sel, BUS_TIMING.zero_wait16}, {i[2:0], 1'b1});
    end
    wr(8'h5F, 8'h01);
    wr(8'h5B, 8'h80);
    IRQ_REQ <= 1'b1;
    tick(2);
    IRQ_REQ <= 1'b0;
    rchk(8'h69, 8'h08);
    wr(8'h69, 8'h08);
    rchk(8'h69, 8'h00);
    MGMT_OUTPUT_N_ACTIVE <= 1'b1;
    tick(3);
    #1 chk(BUS_CLOCK_SLOW, 1'b0);
    wr(8'h5B, 8'h84);
    tick(3);
    #1 chk({BUS_CLOCK_SLOW, BUS_TIMING.clk_sel}, 4'h8);
    @(posedge CLK);
    ARST_N <= 1'b0;
    tick(3);
    ARST_N <= 1'b1;
    rchk(8'h61, 8'h09);
    report_and_stop;
  end
endmodule
`default_nettype wire

//--- verilog/pm_cfg_regs.sv
// Configuration bank for cache, management, stop clock and bus timing.
// Assumes synchronous inputs and a strobe register port read one cycle later.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - override forces two-clock first cache cycle
// - bit four reads slow speed switch
// - fast burst writes on a write-back CPU only when bit set
// - management requests only while mode enabled
// - read 043h then 070h asserts stop clock
// - auto stop clock on timer, break, software
// - select bit picks IRQ line or pin
// - channel bit picks IRQ12 or IRQ15
// - slow bus clock during scaling, 30ms restore
// - active-low relocation with size and shadow conditions
// - vector fetch monitor excludes three masked vectors
// - shared pin mux and flash strobe level
// - standby reload events also reload event timer
// - two-bit time base for both timers
// - break events raise interrupt, set status bit
// - bus clock select: fixed or divided input
// - three bus command timing enable bits
// - recovery clocks per 16 and 8 bit codes
// - wait states per 16 and 8 bit width
// - management memory area and pin timing mode
// - management memory access gated by active input
// - four enables for idle break sources
module pm_cfg_regs
  import pm_cfg_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  input  wire pm_cfg_pkg::io_cycle_t IO_CYCLE,
  input  wire logic        SLOW_SPEED_SWITCH,
  input  wire logic        WRITEBACK_CPU,
  input  wire logic        TIMER_EXPIRED,
  input  wire logic        BREAK_SWITCH,
  input  wire logic        SW_PORT_HIT,
  input  wire logic        STANDBY_RELOAD_EVENT,
  input  wire logic        MGMT_OUTPUT_N_ACTIVE,
  input  wire logic        MGMT_OUTPUT_ZERO,
  input  wire logic        SHADOW_D_E,
  input  wire logic [3:0]  DRAM_SIZE_MB,
  input  wire logic        VECTOR_FETCH,
  input  wire logic [9:0]  FETCH_ADDR,
  input  wire logic        MGMT_ACTIVE_INPUT_N,
  input  wire logic        RAM_CYCLE,
  input  wire logic        IRQ_REQ,
  input  wire logic        NMI_REQ,
  input  wire logic        DMA_REQ,
  input  wire logic        MASTER_REQ,
  output logic             CACHE_FIRST_2T,
  output logic             BURST_FAST_OK,
  output logic             CAS_DELAY_1T,
  output logic             STOP_CLOCK_REQUEST_N,
  output logic             MGMT_INTERRUPT_PIN_N,
  output logic             IRQ12_REQ,
  output logic             IRQ15_REQ,
  output logic             BUS_CLOCK_SLOW,
  output logic             RELOCATE_256K,
  output logic             VECTOR_EVENT,
  output logic             SHARED_PIN,
  output logic             EVENT_TIMER_RELOAD,
  output logic      [1:0]  TIME_BASE,
  output bus_timing_t      BUS_TIMING,
  output logic      [2:0]  MGMT_MEMORY_AREA,
  output logic             ALT_PIN_TIMING,
  output logic             MGMT_MEMORY_ALLOW,
  output logic             IDLE_BREAK
);

  // ==========================================================
  // Register storage
  logic [7:0] cache_timing_q;
  logic [7:0] mgmt_mode_q;
  logic [7:0] trap_q [3];
  logic [7:0] flash_tb_q;
  logic [7:0] bus_clock_q;
  logic [7:0] bus_recovery_q;
  logic [7:0] rsvd_62_q;
  logic [7:0] ram_break_q;
  logic [7:0] req_status_q;
  arm_state_t arm_q;
  logic       stop_q;
  logic       scaling;
  logic       bus_slow;
  logic       mgmt_event;
  logic       break_event;
  logic       trapped;

  function automatic logic hit(input logic [7:0] idx);
    hit = (REG_ADDR == idx);
  endfunction

  function automatic logic [4:0] rec16(input logic [1:0] code);
    case (code)
      2'b00:   rec16 = 5'd8;
      2'b01:   rec16 = 5'd5;
      2'b10:   rec16 = 5'd3;
      default: rec16 = 5'd2;
    endcase
  endfunction

  function automatic logic [4:0] rec8(input logic [1:0] code);
    case (code)
      2'b00:   rec8 = 5'd16;
      2'b01:   rec8 = 5'd11;
      2'b10:   rec8 = 5'd7;
      default: rec8 = 5'd4;
    endcase
  endfunction

  // ==========================================================
  // Register writes; reserved bits stored as written
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cache_timing_q <= RST_CACHE_TIMING;
      mgmt_mode_q    <= RST_MGMT_MODE;
      flash_tb_q     <= RST_FLASH_TB;
      bus_clock_q    <= RST_BUS_CLOCK;
      bus_recovery_q <= RST_BUS_RECOVERY;
      rsvd_62_q      <= RST_RSVD_62;
      ram_break_q    <= RST_RAM_BREAK;
    end else if (REG_WR) begin
      if (hit(IDX_CACHE_TIMING)) begin
        // Status bit stays read-only
        cache_timing_q <= REG_WDATA & 8'hEF;
      end
      if (hit(IDX_MGMT_MODE)) begin
        mgmt_mode_q <= REG_WDATA;
      end
      if (hit(IDX_FLASH_TB)) begin
        flash_tb_q <= REG_WDATA;
      end
      if (hit(IDX_BUS_CLOCK)) begin
        bus_clock_q <= REG_WDATA;
      end
      if (hit(IDX_BUS_RECOVERY)) begin
        bus_recovery_q <= REG_WDATA;
      end
      if (hit(IDX_RSVD_62)) begin
        rsvd_62_q <= REG_WDATA;
      end
      if (hit(IDX_RAM_BREAK)) begin
        ram_break_q <= REG_WDATA;
      end
    end
  end

  // ==========================================================
  // Vector trap masks
  for (genvar i = 0; i < 3; i++) begin : g_trap
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        trap_q[i] <= RST_TRAP;
      end else if (REG_WR && hit(IDX_TRAP_ONE + 8'(i))) begin
        trap_q[i] <= REG_WDATA;
      end
    end
  end

  assign trapped = (FETCH_ADDR[9:2] == trap_q[0])
                 | (FETCH_ADDR[9:2] == trap_q[1])
                 | (FETCH_ADDR[9:2] == trap_q[2]);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      VECTOR_EVENT <= 1'b0;
    end else begin
      VECTOR_EVENT <= VECTOR_FETCH && !trapped;
    end
  end

  // ==========================================================
  // Stop clock port sequence and auto generation
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      arm_q <= ARM_IDLE;
    end else if (IO_CYCLE.rd || IO_CYCLE.wr) begin
      // Any other I/O access between the two reads breaks the sequence
      unique case (arm_q)
        ARM_IDLE: arm_q <= (IO_CYCLE.rd && IO_CYCLE.addr == 16'(IO_PORT_ARM))
                           ? ARM_SEEN : ARM_IDLE;
        ARM_SEEN: arm_q <= (IO_CYCLE.rd && IO_CYCLE.addr == 16'(IO_PORT_ARM))
                           ? ARM_SEEN : ARM_IDLE;
      endcase
    end
  end

  assign break_event = (IRQ_REQ && ram_break_q[3])
                     | (NMI_REQ && ram_break_q[2])
                     | (DMA_REQ && ram_break_q[1])
                     | (MASTER_REQ && ram_break_q[0]);

  // Held until a break event or both stop enables drop
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stop_q <= 1'b0;
    end else if (!mgmt_mode_q[B_STOP_EN] && !mgmt_mode_q[B_STOP_AUTO]) begin
      stop_q <= 1'b0;
    end else if (mgmt_mode_q[B_STOP_EN] && arm_q == ARM_SEEN && IO_CYCLE.rd
                 && IO_CYCLE.addr == 16'(IO_PORT_FIRE)) begin
      stop_q <= 1'b1;
    end else if (mgmt_mode_q[B_STOP_AUTO]
                 && (TIMER_EXPIRED || BREAK_SWITCH || SW_PORT_HIT)) begin
      stop_q <= 1'b1;
    end else if (break_event) begin
      stop_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      STOP_CLOCK_REQUEST_N <= 1'b1;
      IDLE_BREAK           <= 1'b0;
    end else begin
      STOP_CLOCK_REQUEST_N <= !stop_q;
      IDLE_BREAK           <= break_event;
    end
  end

  // ==========================================================
  // Management requests and status
  assign mgmt_event = TIMER_EXPIRED || SW_PORT_HIT || BREAK_SWITCH
                    || (break_event && flash_tb_q[B_BREAK_INT]);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MGMT_INTERRUPT_PIN_N <= 1'b1;
      IRQ12_REQ            <= 1'b0;
      IRQ15_REQ            <= 1'b0;
    end else begin
      // Gated by the mode enable, routing
      MGMT_INTERRUPT_PIN_N <= !(mgmt_mode_q[B_MGMT_EN] && mgmt_event
                               && mgmt_mode_q[B_REQ_BY_PIN]);
      IRQ12_REQ <= mgmt_mode_q[B_MGMT_EN] && mgmt_event
                   && !mgmt_mode_q[B_REQ_BY_PIN] && !mgmt_mode_q[B_IRQ_SEL];
      IRQ15_REQ <= mgmt_mode_q[B_MGMT_EN] && mgmt_event
                   && !mgmt_mode_q[B_REQ_BY_PIN] && mgmt_mode_q[B_IRQ_SEL];
    end
  end

  // Set wins over the write-one clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      req_status_q <= 8'h00;
    end else if (break_event && flash_tb_q[B_BREAK_INT]
                 && mgmt_mode_q[B_MGMT_EN]) begin
      req_status_q[B_STAT_BREAK] <= 1'b1;
    end else if (REG_WR && hit(IDX_REQ_STATUS)
                 && REG_WDATA[B_STAT_BREAK]) begin
      req_status_q[B_STAT_BREAK] <= 1'b0;
    end
  end

  // ==========================================================
  // Bus clock auto switch
  assign scaling = MGMT_OUTPUT_N_ACTIVE || stop_q;

  pm_cfg_restore_timer u_restore (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .enable  (mgmt_mode_q[B_CLK_AUTO]),
    .scaling (scaling),
    .slow_q  (bus_slow)
  );

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUS_CLOCK_SLOW <= 1'b0;
      BUS_TIMING     <= '0;
    end else begin
      BUS_CLOCK_SLOW <= bus_slow;
      // Fixed clock forced while slowed
      BUS_TIMING.clk_sel <= bus_slow ? 3'b000
                            : bus_clock_q[B_BCLK_LO +: 3];
      BUS_TIMING.zero_wait16   <= bus_clock_q[B_ZERO_WAIT];
      BUS_TIMING.read_no_delay <= bus_clock_q[B_NO_CMD_DELAY];
      BUS_TIMING.read_short    <= bus_clock_q[B_SHORT_READ];
      BUS_TIMING.rec16_clks <= rec16(bus_recovery_q[B_REC16_LO +: 2]);
      BUS_TIMING.rec8_clks  <= rec8(bus_recovery_q[B_REC8_LO +: 2]);
      BUS_TIMING.wait16 <= bus_recovery_q[B_WAIT16] ? 3'd1 : 3'd2;
      BUS_TIMING.wait8  <= bus_recovery_q[B_WAIT8] ? 3'd4 : 3'd5;
    end
  end

  // ==========================================================
  // Cache, memory and pin controls
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CACHE_FIRST_2T     <= 1'b0;
      BURST_FAST_OK      <= 1'b0;
      CAS_DELAY_1T       <= 1'b0;
      RELOCATE_256K      <= 1'b0;
      SHARED_PIN         <= 1'b0;
      EVENT_TIMER_RELOAD <= 1'b0;
      TIME_BASE          <= 2'b00;
      MGMT_MEMORY_AREA   <= 3'b000;
      ALT_PIN_TIMING     <= 1'b0;
      MGMT_MEMORY_ALLOW  <= 1'b0;
    end else begin
      CACHE_FIRST_2T <= cache_timing_q[B_CACHE_2T];
      // Other CPUs always get fast burst, whatever the bit
      BURST_FAST_OK  <= !WRITEBACK_CPU || cache_timing_q[B_BURST_FAST];
      CAS_DELAY_1T   <= cache_timing_q[B_CAS_DELAY];
      RELOCATE_256K  <= !mgmt_mode_q[B_RELOC_N] && !SHADOW_D_E
                        && (DRAM_SIZE_MB inside {4'd1, 4'd2, 4'd4, 4'd5,
                                                 4'd6, 4'd8});
      if (flash_tb_q[B_PIN_MUX]) begin
        SHARED_PIN <= !flash_tb_q[B_STROBE_PROG]
                      || flash_tb_q[B_STROBE_LVL];
      end else begin
        SHARED_PIN <= MGMT_OUTPUT_ZERO;
      end
      EVENT_TIMER_RELOAD <= STANDBY_RELOAD_EVENT
                            && flash_tb_q[B_RELOAD_ALL];
      TIME_BASE <= flash_tb_q[B_TB_LO +: 2];
      MGMT_MEMORY_AREA <= ram_break_q[B_RAM_AREA_LO +: 3];
      ALT_PIN_TIMING   <= ram_break_q[7];
      MGMT_MEMORY_ALLOW <= RAM_CYCLE && (!MGMT_ACTIVE_INPUT_N
                           || ram_break_q[B_RAM_OPEN]);
    end
  end

  // ==========================================================
  // Read port: data one cycle on, unmapped reads zero
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        IDX_CACHE_TIMING: REG_RDATA <= {cache_timing_q[7:5], SLOW_SPEED_SWITCH,
                                        cache_timing_q[3:0]};
        IDX_MGMT_MODE:    REG_RDATA <= mgmt_mode_q;
        IDX_TRAP_ONE:     REG_RDATA <= trap_q[0];
        IDX_TRAP_TWO:     REG_RDATA <= trap_q[1];
        IDX_TRAP_THREE:   REG_RDATA <= trap_q[2];
        IDX_FLASH_TB:     REG_RDATA <= flash_tb_q;
        IDX_BUS_CLOCK:    REG_RDATA <= bus_clock_q;
        IDX_BUS_RECOVERY: REG_RDATA <= bus_recovery_q;
        IDX_RSVD_62:      REG_RDATA <= rsvd_62_q;
        IDX_RAM_BREAK:    REG_RDATA <= ram_break_q;
        IDX_REQ_STATUS:   REG_RDATA <= req_status_q;
        default:          REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

endmodule
`default_nettype wire

//--- verilog/pm_cfg_restore_timer.sv
// Holds the bus clock slow until the restore delay ends.
// Assumes the scaling level is synchronous to CLK.
`timescale 1ns/1ns
`default_nettype none
module pm_cfg_restore_timer #(
  parameter int CYCLES = pm_cfg_pkg::RESTORE_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic enable,
  input  wire logic scaling,
  output logic      slow_q
);
  import pm_cfg_pkg::*;

  logic [31:0] count_q;

  // ==========================================================
  // Stays slow while scaling, then for the restore delay after
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= 32'h0000_0000;
      slow_q  <= 1'b0;
    end else if (!enable) begin
      count_q <= 32'h0000_0000;
      slow_q  <= 1'b0;
    end else if (scaling) begin
      count_q <= 32'(CYCLES);
      slow_q  <= 1'b1;
    end else if (count_q != 32'h0000_0000) begin
      count_q <= count_q - 32'h0000_0001;
      slow_q  <= (count_q != 32'h0000_0001);
    end else begin
      slow_q  <= 1'b0;
    end
  end
endmodule
`default_nettype wire
